// ===== sdm_consts.vh
/*
 * Constants of the signed dual multiply-accumulate datapath: register
 * byte offsets, control field positions, operation codes and reset values.
 * Assumes a 32-bit APB slave with every register on an aligned word.
 */
`ifndef SDM_CONSTS_VH
`define SDM_CONSTS_VH

// Register byte offsets
`define SDM_OFF_FIRST_OPERAND 8'h00
`define SDM_OFF_SECOND_OPERAND 8'h04
`define SDM_OFF_ACC_LOW 8'h08
`define SDM_OFF_ACC_HIGH 8'h0C
`define SDM_OFF_CTRL 8'h10
`define SDM_OFF_RESULT_LOW 8'h14
`define SDM_OFF_RESULT_HIGH 8'h18
`define SDM_OFF_STATUS_WORD 8'h1C
`define SDM_OFF_IRQ_STATUS 8'h20
`define SDM_OFF_IRQ_MASK 8'h24

// Control register fields
`define SDM_CTRL_OP_LSB 0
`define SDM_CTRL_OP_MSB 2
`define SDM_CTRL_SEL_BIT 3
`define SDM_CTRL_ROUND_BIT 4
`define SDM_CTRL_COND_BIT 5
`define SDM_CTRL_ACC_IDX_LSB 8
`define SDM_CTRL_ACC_IDX_MSB 11
`define SDM_CTRL_GO_BIT 31

// Operation codes
`define SDM_OP_WORD_HALF_MUL_ACC 3'h0
`define SDM_OP_DUAL_MUL_SUB_ACC 3'h1
`define SDM_OP_DUAL_MUL_SUB_LONG_ACC 3'h2
`define SDM_OP_MSW_MUL_ACC 3'h3
`define SDM_OP_MSW_MUL_SUB 3'h4

// Escape value of the accumulate index field
`define SDM_ACC_IDX_NONE 4'hF

// Status and interrupt bits
`define SDM_SAT_BIT 0
`define SDM_IRQ_DONE_BIT 0
`define SDM_IRQ_SAT_BIT 1

// Misc values
`define SDM_ROUND_CONST 64'h0000000080000000
`define SDM_WORD_RESET 32'h00000000
`define SDM_CTRL_MASK 32'h00000F3F
`define SDM_IRQ_BITS_MASK 32'h00000003
`define SDM_WH_OVF_POS 6'h2F
`define SDM_DUAL_OVF_POS 6'h1F

`endif

// ===== sdm_datapath.v
/*
 * Signed dual multiply-accumulate datapath with an APB register file,
 * sticky saturation flag and a masked level interrupt.
 * Assumes APB signals synchronous to ref_clk and a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sdm_consts.vh"

module sdm_datapath (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Interrupt
	output reg irq
);

	reg [31:0] first_operand;
	reg [31:0] second_operand;
	reg [31:0] acc_low;
	reg [31:0] acc_high;
	reg [31:0] ctrl;
	reg [31:0] result_low;
	reg [31:0] result_high;
	reg sat_flag;
	reg [1:0] irq_status;
	reg [1:0] irq_mask;

	reg [31:0] next_prdata;
	reg next_slverr;
	reg [31:0] next_result_low;
	reg [31:0] next_result_high;
	reg next_sat;
	reg next_write_acc;

	// True when bits above pos disagree with bit pos
	function ovf_check;
		input [63:0] v;
		input [5:0] pos;
		integer i;
		begin
			ovf_check = 1'b0;
			for (i = 0; i < 64; i = i + 1) begin
				if (i > pos && v[i] != v[pos])
					ovf_check = 1'b1;
			end
		end
	endfunction

	function addr_mapped;
		input [7:0] a;
		begin
			addr_mapped = (a == `SDM_OFF_FIRST_OPERAND) || (a == `SDM_OFF_SECOND_OPERAND) ||
				(a == `SDM_OFF_ACC_LOW) || (a == `SDM_OFF_ACC_HIGH) ||
				(a == `SDM_OFF_CTRL) || (a == `SDM_OFF_RESULT_LOW) ||
				(a == `SDM_OFF_RESULT_HIGH) || (a == `SDM_OFF_STATUS_WORD) ||
				(a == `SDM_OFF_IRQ_STATUS) || (a == `SDM_OFF_IRQ_MASK);
		end
	endfunction

	wire setup = psel && !penable;
	wire access_done = psel && penable && pready;
	wire wr = access_done && pwrite && !pslverr;
	wire rd = access_done && !pwrite && !pslverr;
	wire go = wr && paddr == `SDM_OFF_CTRL && pwdata[`SDM_CTRL_GO_BIT];

	// The operation runs on the control word being written
	wire [2:0] op = pwdata[`SDM_CTRL_OP_MSB:`SDM_CTRL_OP_LSB];
	wire sel = pwdata[`SDM_CTRL_SEL_BIT];
	wire round = pwdata[`SDM_CTRL_ROUND_BIT];
	wire cond_pass = pwdata[`SDM_CTRL_COND_BIT];
	wire no_acc = pwdata[`SDM_CTRL_ACC_IDX_MSB:`SDM_CTRL_ACC_IDX_LSB] == `SDM_ACC_IDX_NONE;

	// Word by halfword
	wire [15:0] half = sel ? second_operand[31:16] : second_operand[15:0];
	wire [47:0] wh_prod = $signed(first_operand) * $signed(half);
	wire [63:0] wh_sum = {{16{wh_prod[47]}}, wh_prod} +
		{{16{acc_low[31]}}, acc_low, 16'h0000};

	// Dual products
	wire [31:0] rot_operand = sel ? {second_operand[15:0], second_operand[31:16]} :
		second_operand;
	wire [31:0] prod_low = $signed(first_operand[15:0]) * $signed(rot_operand[15:0]);
	wire [31:0] prod_high = $signed(first_operand[31:16]) * $signed(rot_operand[31:16]);
	wire [63:0] dual_diff = {{32{prod_low[31]}}, prod_low} -
		{{32{prod_high[31]}}, prod_high};
	wire [63:0] dual_acc = no_acc ? 64'h0 : {{32{acc_low[31]}}, acc_low};
	wire [63:0] dual_sum = dual_diff + dual_acc;
	// Modulo 2^64 on purpose, no carry out is kept
	wire [63:0] long_sum = dual_diff + {acc_high, acc_low};

	// Most significant word
	wire [63:0] msw_prod = $signed(first_operand) * $signed(second_operand);
	wire [63:0] msw_base = {acc_low, 32'h00000000};
	wire [63:0] msw_acc_base = no_acc ? 64'h0 : msw_base;
	wire [63:0] msw_round = round ? `SDM_ROUND_CONST : 64'h0;
	wire [63:0] msw_add = msw_acc_base + msw_prod + msw_round;
	wire [63:0] msw_sub = msw_base - msw_prod + msw_round;

	// Operation select; registers keep their value unless the condition passed
	always @* begin
		next_result_low = result_low;
		next_result_high = result_high;
		next_sat = 1'b0;
		next_write_acc = 1'b0;
		if (go && cond_pass) begin
			case (op)
				`SDM_OP_WORD_HALF_MUL_ACC: begin
					next_result_low = wh_sum[47:16];
					next_sat = ovf_check(wh_sum, `SDM_WH_OVF_POS);
				end
				`SDM_OP_DUAL_MUL_SUB_ACC: begin
					next_result_low = dual_sum[31:0];
					next_sat = ovf_check(dual_sum, `SDM_DUAL_OVF_POS);
				end
				`SDM_OP_DUAL_MUL_SUB_LONG_ACC: begin
					next_result_low = long_sum[31:0];
					next_result_high = long_sum[63:32];
					next_write_acc = 1'b1;
				end
				`SDM_OP_MSW_MUL_ACC: begin
					next_result_low = msw_add[63:32];
				end
				`SDM_OP_MSW_MUL_SUB: begin
					next_result_low = msw_sub[63:32];
				end
				default: begin
					next_result_low = result_low;
				end
			endcase
		end
	end

	// Read mux
	always @* begin
		next_slverr = !addr_mapped(paddr);
		case (paddr)
			`SDM_OFF_FIRST_OPERAND: next_prdata = first_operand;
			`SDM_OFF_SECOND_OPERAND: next_prdata = second_operand;
			`SDM_OFF_ACC_LOW: next_prdata = acc_low;
			`SDM_OFF_ACC_HIGH: next_prdata = acc_high;
			`SDM_OFF_CTRL: next_prdata = ctrl & `SDM_CTRL_MASK;
			`SDM_OFF_RESULT_LOW: next_prdata = result_low;
			`SDM_OFF_RESULT_HIGH: next_prdata = result_high;
			`SDM_OFF_STATUS_WORD: next_prdata = {31'h0000000, sat_flag};
			`SDM_OFF_IRQ_STATUS: next_prdata = {30'h0000000, irq_status};
			`SDM_OFF_IRQ_MASK: next_prdata = {30'h0000000, irq_mask};
			default: next_prdata = `SDM_WORD_RESET;
		endcase
	end

	// APB handshake: one access cycle, no wait states
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `SDM_WORD_RESET;
		end else begin
			pready <= setup;
			pslverr <= setup && next_slverr;
			if (setup && !pwrite)
				prdata <= next_prdata;
			else if (access_done)
				prdata <= `SDM_WORD_RESET;
		end
	end

	// Register file
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			first_operand <= `SDM_WORD_RESET;
			second_operand <= `SDM_WORD_RESET;
			acc_low <= `SDM_WORD_RESET;
			acc_high <= `SDM_WORD_RESET;
			ctrl <= `SDM_WORD_RESET;
			result_low <= `SDM_WORD_RESET;
			result_high <= `SDM_WORD_RESET;
			irq_mask <= 2'b00;
		end else begin
			result_low <= next_result_low;
			result_high <= next_result_high;
			if (next_write_acc) begin
				acc_low <= next_result_low;
				acc_high <= next_result_high;
			end else if (wr && paddr == `SDM_OFF_ACC_LOW) begin
				acc_low <= pwdata;
			end else if (wr && paddr == `SDM_OFF_ACC_HIGH) begin
				acc_high <= pwdata;
			end
			if (wr && paddr == `SDM_OFF_FIRST_OPERAND)
				first_operand <= pwdata;
			if (wr && paddr == `SDM_OFF_SECOND_OPERAND)
				second_operand <= pwdata;
			if (wr && paddr == `SDM_OFF_CTRL)
				ctrl <= pwdata & `SDM_CTRL_MASK;
			if (wr && paddr == `SDM_OFF_IRQ_MASK)
				irq_mask <= pwdata[1:0];
		end
	end

	// Sticky flags; a hardware set in the clearing cycle wins
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sat_flag <= 1'b0;
			irq_status <= 2'b00;
			irq <= 1'b0;
		end else begin
			if (next_sat)
				sat_flag <= 1'b1;
			else if (wr && paddr == `SDM_OFF_STATUS_WORD && pwdata[`SDM_SAT_BIT])
				sat_flag <= 1'b0;
			irq_status[`SDM_IRQ_DONE_BIT] <= go ||
				(irq_status[`SDM_IRQ_DONE_BIT] && !(rd && paddr == `SDM_OFF_IRQ_STATUS));
			irq_status[`SDM_IRQ_SAT_BIT] <= next_sat ||
				(irq_status[`SDM_IRQ_SAT_BIT] && !(rd && paddr == `SDM_OFF_IRQ_STATUS));
			// Registered one cycle behind the status bits
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule
`default_nettype wire

// ===== sdm_datapath_assertions.sv
/* Bus and interrupt checks. Assumes the datapath's port list only. */
`timescale 1ns/1ps
`default_nettype none
module sdm_checker (
	// Ports of the datapath
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle_zero: assert property (!pready || pwrite |-> prdata == 32'h0)
		else $error("read data outside read");
	a_err_unmapped: assert property (psel && !penable && paddr > 8'h24 |=> pslverr)
		else $error("unmapped not refused");
	a_err_mapped_ok: assert property (psel && !penable && paddr < 8'h28 && paddr[1:0] == 2'h0
		|=> !pslverr)
		else $error("mapped refused");
	a_status_one_bit: assert property (pready && !pwrite && paddr == 8'h1C |-> prdata[31:1] == 31'h0)
		else $error("status spare bits set");
	a_irq_after_xfer: assert property ($changed(irq) |-> $past(pready, 2))
		else $error("irq moved without a transfer");
endmodule
bind sdm_datapath sdm_checker i_sdm_checker (.ref_clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
`default_nettype wire

// ===== sdm_datapath_tb.sv
/* Random self-checking bench against a behavioural model. Assumes sdm_host. */
`timescale 1ns/1ps
`default_nettype none
module sdm_datapath_tb;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	wire logic psel, penable, pwrite, pready, pslverr, irq;
	wire logic [7:0] paddr;
	wire logic [31:0] pwdata, prdata;
	int n_errors = 0;
	int n_compared = 0;
	logic [2:0] op;
	logic s, r, k, e, sat, sev;
	logic [1:0] mk;
	logic [3:0] x;
	logic [31:0] a, b, lo, hi, rh, res, q, w, m;
	longint f, p, ac, rc;
	always #25 ref_clk = ~ref_clk;
	sdm_host i_sdm_host (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	sdm_datapath i_sdm_datapath (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq);
	task chk(input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] d);
		i_sdm_host.xfer(1'h1, ad, d, q, e);
	endtask
	task rd(input logic [7:0] ad, input logic [31:0] exp);
		i_sdm_host.xfer(1'h0, ad, 32'h0, q, e);
		chk(q, exp);
	endtask
	task complete_run;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#2000000;
		n_errors++;
		complete_run();
	end
	initial begin
		{sat, sev, rh, res} = 66'h0;
		void'($urandom(86492));
		repeat (6) @(posedge ref_clk);
		rst <= 1'h0;
		for (int i = 0; i < 200; i++) begin
			{a, b, lo, hi, w} = {$urandom, $urandom, $urandom, $urandom, $urandom};
			op = $urandom % 6;
			{s, r, k, mk} = $urandom;
			x = $urandom % 3 ? 4'h3 : 4'hF;
			wr(8'h24, {30'h0, mk});
			wr(8'h1C, w);
			sat = sat & ~w[0];
			wr(8'h00, a);
			wr(8'h04, b);
			wr(8'h08, lo);
			wr(8'h0C, hi);
			wr(8'h10, {1'h1, 19'h0, x, 2'h0, k, r, s, op});
			m = s ? {b[15:0], b[31:16]} : b;
			p = $signed(a[15:0]) * $signed(m[15:0]) - $signed(a[31:16]) * $signed(m[31:16]);
			ac = (x == 4'hF && op[0]) ? 0 : $signed(lo);
			rc = r ? 64'sh80000000 : 64'sh0;
			case (op)
				3'h0: f = $signed(a) * $signed(s ? b[31:16] : b[15:0]) + (ac <<< 16);
				3'h1: f = p + ac;
				3'h2: f = p + longint'({hi, lo});
				3'h3: f = (ac <<< 32) + $signed(a) * $signed(b) + rc;
				3'h4: f = (ac <<< 32) - $signed(a) * $signed(b) + rc;
				// Spare codes leave every result alone
				default: f = 64'sh0;
			endcase
			if (k && op < 3'h5) begin
				res = op == 3'h0 ? f[47:16] : op > 3'h2 ? f[63:32] : f[31:0];
				if (op == 3'h2)
					rh = f[63:32];
				if (op == 3'h2)
					hi = rh;
				if (op == 3'h2)
					lo = res;
				sev = (op == 3'h0 && f >>> 16 != $signed(res)) || (op == 3'h1 && f != $signed(res));
				sat = sat | sev;
			end
			rd(8'h10, {20'h0, x, 2'h0, k, r, s, op});
			rd(8'h14, res);
			rd(8'h18, rh);
			rd(8'h08, lo);
			rd(8'h0C, hi);
			rd(8'h1C, {31'h0, sat});
			chk({31'h0, irq}, {31'h0, |({sev, 1'h1} & mk)});
			rd(8'h20, {30'h0, sev, 1'h1});
			sev = 1'h0;
			repeat (2) @(posedge ref_clk);
			chk({31'h0, irq}, 32'h0);
		end
		// Result registers are read-only; unmapped space refused
		wr(8'h14, 32'hFFFFFFFF);
		rd(8'h14, res);
		rd(8'h28, 32'h0);
		chk({31'h0, e}, 32'h1);
		complete_run();
	end
endmodule
`default_nettype wire

// ===== sdm_host.sv
/* APB master standing for the decode side. Assumes a registered pready. */
`timescale 1ns/1ps
`default_nettype none
module sdm_host (
	// Clock
	input wire logic ref_clk,
	// Bus
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Stale data would hide a late capture
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire
